// ==== dv/or_and_move_instruction_exec_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module or_and_move_instruction_exec_bench;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0] acc_out;
  logic zero_out;
  logic [1:0] quarter_out;
  logic file_wr_en;
  logic [6:0] file_wr_addr;
  logic [7:0] file_wr_data;
  logic instr_done;
  logic instr_unsupported;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int m_acc = 0;
  int m_zero = 0;
  int mem [128];
  logic [31:0] seed = 32'h00011c24;

  // Free-running 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  oam_core i_dut (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .instr_word(instr_word),
    .acc_out(acc_out),
    .zero_out(zero_out),
    .quarter_out(quarter_out),
    .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr),
    .file_wr_data(file_wr_data),
    .instr_done(instr_done),
    .instr_unsupported(instr_unsupported)
  );

  // Xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Reset held six cycles; RAM keeps its contents, so the model keeps mem
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    chk({acc_out, zero_out, quarter_out}, 16'h0000);
    chk({file_wr_en, instr_done, instr_unsupported}, 16'h0000);
    sys_rst = 1'b0;
    m_acc = 0;
    m_zero = 0;
    $display("test reset done");
  endtask

  // One instruction, entered just after the edge that opens Q1
  task automatic exec(input logic [13:0] w);
    int op, a, d, lit, r, we, wd;
    logic [31:0] j;
    a = w[6:0];
    d = w[7];
    lit = w[7:0];
    we = 0;
    wd = 0;
    if (w[13:8] == 6'h38) op = 1;
    else if (w[13:8] == 6'h04) op = 2;
    else if (w[13:8] == 6'h08) op = 3;
    else if (w[13:10] == 4'hc) op = 4;
    else if (w[13:7] == 7'h01) op = 5;
    else op = 0;
    case (op)
      1: begin
        m_acc = m_acc | lit;
        m_zero = (m_acc == 0);
      end
      2, 3: begin
        r = (op == 2) ? (m_acc | mem[a]) : mem[a];
        m_zero = (r == 0);
        if (d != 0) begin
          we = 1;
          wd = r;
          mem[a] = r;
        end else m_acc = r;
      end
      4: m_acc = lit;
      5: begin
        we = 1;
        wd = m_acc;
        mem[a] = m_acc;
      end
      default: ;
    endcase
    instr_word = w;
    @(posedge ref_clk);
    // Junk outside Q1 must be ignored
    #1 j = rnd();
    instr_word = j[13:0];
    repeat (2) @(posedge ref_clk);
    #1;
    chk({quarter_out, file_wr_en}, {2'h3, we[0]});
    if (we != 0) chk({file_wr_addr, file_wr_data}, {a[6:0], wd[7:0]});
    @(posedge ref_clk);
    #1;
    chk({quarter_out, instr_done, instr_unsupported, file_wr_en}, {2'h0, 1'b1, op == 0, 1'b0});
    chk({zero_out, acc_out}, {m_zero[0], m_acc[7:0]});
  endtask

  // Hang guard, well above the ~2700 cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 6000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    logic [31:0] j;
    logic [7:0] l;
    logic [13:0] w;
    do_reset();
    exec({4'hc, 2'h0, 8'h9a});
    exec({6'h38, 8'h35});
    // Zero result sets the flag; zero prefix with bit 7 clear must not store
    exec({4'hc, 2'h3, 8'h00});
    exec({6'h38, 8'h00});
    exec({7'h00, 7'h15});
    $display("test literal_or done");
    // Fill every address, zeros mixed in for zero-flag cases
    for (int i = 0; i < 128; i++) begin
      j = rnd();
      l = (j[10:8] == 3'h0) ? 8'h00 : j[7:0];
      exec({4'hc, j[12:11], l});
      exec({7'h01, i[6:0]});
    end
    $display("test preload done");
    for (int n = 0; n < 400; n++) begin
      j = rnd();
      l = (j[10:8] == 3'h0) ? 8'h00 : j[7:0];
      case (j[18:16])
        3'h0: w = {6'h38, l};
        3'h1: w = {6'h04, j[7:0]};
        3'h2: w = {6'h08, j[7:0]};
        3'h3: w = {4'hc, j[12:11], l};
        3'h4: w = {7'h01, j[6:0]};
        default: w = j[29:16];
      endcase
      exec(w);
      if (n == 200) do_reset();
    end
    $display("test random_mix done");
    tally_and_finish();
  end
endmodule // or_and_move_instruction_exec_bench
`default_nettype wire

// ==== verilog/oam_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module oam_core (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [13:0] instr_word,
  output logic [7:0] acc_out,
  output logic zero_out,
  output logic [1:0] quarter_out,
  output logic file_wr_en,
  output logic [6:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  output logic instr_done,
  output logic instr_unsupported
);

  typedef struct packed {
    oam_pkg::oam_phase_t phase;
    logic [oam_pkg::INSTR_W-1:0] instr;
    oam_pkg::oam_op_t op;
    logic [oam_pkg::DATA_W-1:0] acc;
    logic zero;
    logic [oam_pkg::DATA_W-1:0] result;
    logic wr_en;
    logic [oam_pkg::ADDR_W-1:0] wr_addr;
    logic [oam_pkg::DATA_W-1:0] wr_data;
    logic done;
    logic unsup;
  } oam_state_t;

  oam_state_t st_reg;
  oam_state_t st_next;
  logic [oam_pkg::DATA_W-1:0] file_rd_data;
  logic dest_file;

  // File registers; read address is the latched instruction field
  oam_file_regs #(
    .DEPTH(oam_pkg::FILE_DEPTH),
    .AW(oam_pkg::ADDR_W),
    .DW(oam_pkg::DATA_W)
  ) u_file_regs (
    .ref_clk(ref_clk),
    .rd_addr(st_reg.instr[oam_pkg::ADDR_W-1:0]),
    .rd_data(file_rd_data),
    .wr_en(st_reg.wr_en),
    .wr_addr(st_reg.wr_addr),
    .wr_data(st_reg.wr_data)
  );

  assign dest_file = st_reg.instr[oam_pkg::DEST_BIT];

  // Quarter sequencer and datapath
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.unsup = 1'b0;
    case (st_reg.phase)
      oam_pkg::PH_Q1: begin
        // Decode quarter: word is taken here, no earlier
        st_next.instr = instr_word;
        st_next.op = oam_pkg::decode_op(instr_word);
        st_next.phase = oam_pkg::PH_Q2;
      end
      oam_pkg::PH_Q2: begin
        // Operand read quarter; file RAM samples the address this edge
        st_next.phase = oam_pkg::PH_Q3;
      end
      oam_pkg::PH_Q3: begin
        // Process quarter: compute result and set up any file write
        st_next.wr_en = 1'b0;
        st_next.wr_addr = st_reg.instr[oam_pkg::ADDR_W-1:0];
        case (st_reg.op)
          oam_pkg::OP_OR_LIT: begin
            st_next.result = st_reg.acc | st_reg.instr[oam_pkg::DATA_W-1:0];
          end
          oam_pkg::OP_OR_REG: begin
            st_next.result = st_reg.acc | file_rd_data;
            st_next.wr_en = dest_file;
          end
          oam_pkg::OP_MOVE_REG: begin
            st_next.result = file_rd_data;
            st_next.wr_en = dest_file;
          end
          oam_pkg::OP_LOAD_LIT: begin
            st_next.result = st_reg.instr[oam_pkg::DATA_W-1:0];
          end
          oam_pkg::OP_STORE: begin
            st_next.result = st_reg.acc;
            st_next.wr_en = 1'b1;
          end
          default: begin
            st_next.result = st_reg.result;
          end
        endcase
        st_next.wr_data = st_next.result;
        st_next.phase = oam_pkg::PH_Q4;
      end
      oam_pkg::PH_Q4: begin
        // Write quarter: file write strobe stands now, acc and flag land
        st_next.wr_en = 1'b0;
        case (st_reg.op)
          oam_pkg::OP_OR_LIT: begin
            st_next.acc = st_reg.result;
            st_next.zero = (st_reg.result == 8'h00);
          end
          oam_pkg::OP_OR_REG, oam_pkg::OP_MOVE_REG: begin
            if (!dest_file) begin
              st_next.acc = st_reg.result;
            end
            st_next.zero = (st_reg.result == 8'h00);
          end
          oam_pkg::OP_LOAD_LIT: begin
            st_next.acc = st_reg.result;
          end
          default: begin
            // Store and unknown words leave acc and flag alone
            st_next.acc = st_reg.acc;
          end
        endcase
        st_next.done = 1'b1;
        st_next.unsup = (st_reg.op == oam_pkg::OP_OTHER);
        st_next.phase = oam_pkg::PH_Q1;
      end
      default: begin
        st_next.phase = oam_pkg::PH_Q1;
      end
    endcase
  end

  // State register; synchronous reset restarts at the decode quarter
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg.phase <= oam_pkg::PH_Q1;
      st_reg.instr <= oam_pkg::INSTR_RST;
      st_reg.op <= oam_pkg::OP_OTHER;
      st_reg.acc <= oam_pkg::ACC_RST;
      st_reg.zero <= oam_pkg::ZERO_RST;
      st_reg.result <= oam_pkg::ACC_RST;
      st_reg.wr_en <= 1'b0;
      st_reg.wr_addr <= 7'h00;
      st_reg.wr_data <= 8'h00;
      st_reg.done <= 1'b0;
      st_reg.unsup <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops
  assign acc_out = st_reg.acc;
  assign zero_out = st_reg.zero;
  assign quarter_out = st_reg.phase;
  assign file_wr_en = st_reg.wr_en;
  assign file_wr_addr = st_reg.wr_addr;
  assign file_wr_data = st_reg.wr_data;
  assign instr_done = st_reg.done;
  assign instr_unsupported = st_reg.unsup;

  // Checks: antecedent is the decode quarter with the word on the input, except the quarter-order, write-window and done-pulse checks
  logic at_q1;
  oam_pkg::oam_op_t in_op;
  assign at_q1 = (st_reg.phase == oam_pkg::PH_Q1);
  assign in_op = oam_pkg::decode_op(instr_word);

  chk_quarter_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
    at_q1 |=> st_reg.phase == oam_pkg::PH_Q2 ##1 st_reg.phase == oam_pkg::PH_Q3
      ##1 st_reg.phase == oam_pkg::PH_Q4 ##1 at_q1 && instr_done)
    else $error("quarter sequence broken");

  chk_or_lit_acc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    at_q1 && in_op == oam_pkg::OP_OR_LIT |-> ##4
      acc_out == ($past(acc_out, 4) | $past(instr_word[7:0], 4)) && !$past(file_wr_en, 1))
    else $error("literal OR result wrong");

  chk_zero_value: assert property (@(posedge ref_clk) disable iff (sys_rst)
    at_q1 && (in_op == oam_pkg::OP_OR_LIT || in_op == oam_pkg::OP_OR_REG
      || in_op == oam_pkg::OP_MOVE_REG) |-> ##4 zero_out == ($past(st_reg.result, 1) == 8'h00))
    else $error("zero flag does not match result");

  chk_or_reg_dest: assert property (@(posedge ref_clk) disable iff (sys_rst)
    at_q1 && in_op == oam_pkg::OP_OR_REG |-> ##3
      file_wr_en == $past(instr_word[7], 3) && file_wr_data == ($past(acc_out, 3) | file_wr_data))
    else $error("register OR destination wrong");

  chk_move_acc: assert property (@(posedge ref_clk) disable iff (sys_rst)
    at_q1 && in_op == oam_pkg::OP_MOVE_REG && !instr_word[7] |-> ##4
      acc_out == $past(file_wr_data, 1) && zero_out == (acc_out == 8'h00))
    else $error("register move to acc wrong");

  chk_load_flags: assert property (@(posedge ref_clk) disable iff (sys_rst)
    at_q1 && in_op == oam_pkg::OP_LOAD_LIT |-> ##4
      acc_out == $past(instr_word[7:0], 4) && zero_out == $past(zero_out, 4))
    else $error("literal load wrong or flag touched");

  chk_store_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    at_q1 && in_op == oam_pkg::OP_STORE |-> ##3 file_wr_en
      && file_wr_addr == $past(instr_word[6:0], 3) && file_wr_data == $past(acc_out, 3)
      ##1 zero_out == $past(zero_out, 4) && acc_out == $past(acc_out, 4))
    else $error("store write wrong or state touched");

  chk_store_decode: assert property (@(posedge ref_clk) disable iff (sys_rst)
    at_q1 && instr_word[13:7] == 7'h00 |-> ##3 !file_wr_en)
    else $error("zero prefix without bit 7 wrote a register");

  chk_write_window: assert property (@(posedge ref_clk) disable iff (sys_rst)
    file_wr_en |-> st_reg.phase == oam_pkg::PH_Q4)
    else $error("file write outside write quarter");

  // Zero flag reckoned from the old acc and the literal, not from internal result
  chk_or_lit_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    at_q1 && in_op == oam_pkg::OP_OR_LIT |-> ##4
      zero_out == (($past(acc_out, 4) | $past(instr_word[7:0], 4)) == 8'h00))
    else $error("literal OR zero flag wrong");

  chk_move_file_back: assert property (@(posedge ref_clk) disable iff (sys_rst)
    at_q1 && in_op == oam_pkg::OP_MOVE_REG && instr_word[7] |-> ##3 file_wr_en
      && file_wr_addr == $past(instr_word[6:0], 3) ##1 acc_out == $past(acc_out, 4))
    else $error("register move back to file wrong");

  chk_done_quarter: assert property (@(posedge ref_clk) disable iff (sys_rst)
    instr_done |-> at_q1 && $past(st_reg.phase) == oam_pkg::PH_Q4)
    else $error("done pulse outside decode quarter");

  cov_or_lit_zero: cover property (@(posedge ref_clk) disable iff (sys_rst)
    at_q1 && in_op == oam_pkg::OP_OR_LIT ##4 zero_out);
  cov_or_reg_file: cover property (@(posedge ref_clk) disable iff (sys_rst)
    at_q1 && in_op == oam_pkg::OP_OR_REG && instr_word[7] ##3 file_wr_en);
  cov_store: cover property (@(posedge ref_clk) disable iff (sys_rst)
    at_q1 && in_op == oam_pkg::OP_STORE ##3 file_wr_en);
  cov_unsupported: cover property (@(posedge ref_clk) disable iff (sys_rst)
    instr_unsupported);

endmodule // oam_core
`default_nettype wire

// ==== verilog/oam_file_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module oam_file_regs #(
  parameter int unsigned DEPTH = 128,
  parameter int unsigned AW = 7,
  parameter int unsigned DW = 8
) (
  input wire logic ref_clk,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data
);

  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rd_data_reg;

  // Registered read; contents undefined until written, like real file RAM
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_reg <= mem[rd_addr];
  end

  assign rd_data = rd_data_reg;

endmodule // oam_file_regs
`default_nettype wire

// ==== verilog/oam_pkg.sv ====
// Function
// - Literal OR opcode 111000: acc OR literal into acc, zero flag updated.
// - Register OR opcode 000100: acc OR register, destination bit picks target, zero updated.
// - Register move opcode 001000: register to acc or back to itself, zero updated.
// - Literal load opcode 1100xx: literal into acc, flags untouched.
// - Store copies acc into file register 0 to 127, flags untouched.
// - Store decoded from 0000001 prefix followed by 7-bit address.
// - Every instruction runs four quarters: decode, read, process, write.
`default_nettype none
package oam_pkg;

  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned FILE_DEPTH = 128;

  // Field positions inside the instruction word
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned OP6_LSB = 8;
  localparam int unsigned OP4_LSB = 10;
  localparam int unsigned OP7_LSB = 7;

  // Opcode prefixes
  localparam logic [5:0] OPC_OR_LIT = 6'h38;
  localparam logic [5:0] OPC_OR_REG = 6'h04;
  localparam logic [5:0] OPC_MOVE_REG = 6'h08;
  localparam logic [3:0] OPC_LOAD_LIT = 4'hc;
  localparam logic [6:0] OPC_STORE = 7'h01;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic ZERO_RST = 1'b0;
  localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} oam_phase_t;

  typedef enum logic [2:0] {
    OP_OR_LIT, OP_OR_REG, OP_MOVE_REG, OP_LOAD_LIT, OP_STORE, OP_OTHER
  } oam_op_t;

  // Opcode decode, shared by the core and its checks
  function automatic oam_op_t decode_op(input logic [INSTR_W-1:0] w);
    oam_op_t op;
    op = OP_OTHER;
    if (w[INSTR_W-1:OP6_LSB] == OPC_OR_LIT) op = OP_OR_LIT;
    else if (w[INSTR_W-1:OP6_LSB] == OPC_OR_REG) op = OP_OR_REG;
    else if (w[INSTR_W-1:OP6_LSB] == OPC_MOVE_REG) op = OP_MOVE_REG;
    else if (w[INSTR_W-1:OP4_LSB] == OPC_LOAD_LIT) op = OP_LOAD_LIT;
    else if (w[INSTR_W-1:OP7_LSB] == OPC_STORE) op = OP_STORE;
    return op;
  endfunction

endpackage
`default_nettype wire
